// *** dv/bvs_host.sv ***
// Purpose: host model. Assumes: unlock per write. Notes: data inverted when released
`timescale 1ns/100ps
`default_nettype none
module bvs_host (
	input wire logic clk,
	output var logic [7:0] reg_addr = 8'h00,
	output var logic reg_wr = 1'b0,
	output var logic [7:0] reg_wdata = 8'h00,
	output var logic unlocked = 1'b0
);
	task automatic wr(input logic [7:0] a, d, input logic k);
		@(posedge clk);
		unlocked <= k;
		reg_addr <= a;
		reg_wr <= 1'b1;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		reg_addr <= a;
		@(posedge clk);
	endtask : rd
endmodule : bvs_host
`default_nettype wire

// *** dv/bvs_reg_assertions.sv ***
// Purpose: port checks. Assumes: one clock. Notes: bind at foot
`timescale 1ns/100ps
`default_nettype none
module bvs_chk #(parameter int unsigned BLANK_CYC = 16) (
	input wire logic clk, rst_n, reg_wr, unlocked, light_load,
	input wire logic pulse_skip_active, supervisor_blank,
	input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
	input wire logic [5:0] buck1_voltage_code, buck2_voltage_code,
	input wire logic [10:0] buck1_mv, buck2_mv
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	int unsigned n_r;
	sequence s_wr; reg_wr && reg_addr == 8'h17 && unlocked; endsequence
	sequence s_go; reg_wr && reg_addr == 8'h1A && reg_wdata[1:0] != 2'h0; endsequence
	function automatic logic [10:0] mv(logic [5:0] c);
		return c > 6'h32 ? 11'h546 + 11'h19 * (c - 6'h32) : 11'h352 + 11'hA * c;
	endfunction : mv
	// Cycles since the last accepted write
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n) n_r <= BLANK_CYC;
		else if (reg_wr && reg_addr == 8'h17 && unlocked) n_r <= 0;
		else if (n_r < BLANK_CYC) n_r <= n_r + 1;
	blank_span_a: assert property (supervisor_blank == (n_r < BLANK_CYC)) else $error("blank");
	code_hold_a: assert property (!s_go |=> $stable(buck2_voltage_code)) else $error("hold");
	code_apply_a: assert property (s_wr ##1 s_go |=> buck2_voltage_code == $past(reg_wdata[5:0], 2))
		else $error("apply");
	skip_off_a: assert property ((s_wr and !reg_wdata[7]) ##1 !(reg_wr && reg_addr == 8'h17 && unlocked)
		|=> !pulse_skip_active) else $error("pwm");
	load_gate_a: assert property (!light_load [*4] |-> !pulse_skip_active) else $error("load");
	buck2_mv_a: assert property (buck2_mv == mv(buck2_voltage_code)) else $error("mv2");
	buck1_mv_a: assert property (buck1_mv == mv(buck1_voltage_code)) else $error("mv1");
	rsvd_zero_a: assert property (reg_rdata[6] == 1'b0) else $error("bit6");
endmodule : bvs_chk
bind bvs_reg bvs_chk #(.BLANK_CYC(BLANK_CYC)) u_chk (.*);
`default_nettype wire

// *** dv/bvs_tb_top.sv ***
// Purpose: bench. Assumes: BLANK_CYC 16. Notes: host model drives the bus
`timescale 1ns/100ps
`default_nettype none
module buck_voltage_setting_register_tb_top;
	logic clk = 0, rst_n = 0, light_load = 0, reg_wr, unlocked;
	logic pulse_skip_active, supervisor_blank;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic [5:0] buck1_voltage_code = 6'h24, buck2_voltage_code;
	logic [10:0] buck1_mv, buck2_mv;
	int err_count = 0, checked = 0;
	bvs_reg #(.BLANK_CYC(16)) dut (.*);
	bvs_host u_host (.*);
	initial forever #2.5 clk = ~clk;
	task automatic cmp(input logic [15:0] s, e, input string n);
		checked++;
		if (s !== e) begin
			err_count++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask : cmp
	task automatic rd(input logic [7:0] a, e);
		u_host.rd(a);
		#1 cmp(reg_rdata, e, "rdata");
	endtask : rd
	task automatic t_apply;
		int i;
		u_host.wr(8'h17, 8'h45, 1'b0);
		rd(8'h17, 8'h99);
		u_host.wr(8'h17, 8'h7F, 1'b1);
		rd(8'h17, 8'h3F);
		cmp(buck2_voltage_code, 6'h19, "held");
		u_host.wr(8'h1A, 8'h02, 1'b1);
		#1 cmp(buck2_mv, 11'h68B, "mv2");
		for (i = 0; i < 40 && supervisor_blank; i++) #5;
		cmp(i, 12, "blank");
	endtask : t_apply
	task automatic t_buck1;
		logic [5:0] c[4] = '{6'h00, 6'h24, 6'h32, 6'h3F};
		logic [10:0] m[4] = '{11'h352, 11'h4BA, 11'h546, 11'h68B};
		foreach (c[k]) begin
			@(posedge clk) buck1_voltage_code <= c[k];
			#1 cmp(buck1_mv, m[k], "mv1");
		end
	endtask : t_buck1
	task automatic t_skip;
		@(posedge clk) light_load <= 1'b1;
		u_host.wr(8'h17, 8'h80, 1'b1);
		repeat (4) @(posedge clk);
		#1 cmp(pulse_skip_active, 1'b1, "skip");
		u_host.wr(8'h17, 8'h00, 1'b1);
		repeat (2) @(posedge clk);
		#1 cmp(pulse_skip_active, 1'b0, "pwm");
	endtask : t_skip
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (10) @(posedge clk);
		cmp(buck2_mv, 11'h44C, "rst");
		rst_n <= 1'b1;
		t_apply;
		t_buck1;
		t_skip;
		tally_and_finish;
	end
endmodule : buck_voltage_setting_register_tb_top
`default_nettype wire

// *** verilog/bvs_code_to_mv.sv ***
// Purpose: Maps a 6-bit voltage code to millivolts
// Assumes: Two-slope encoding shared by both converters
// Notes: Purely combinational
`timescale 1ns/100ps
`default_nettype none
`include "bvs_defines.svh"
module bvs_code_to_mv
	import bvs_pkg::*;
(
	// Code in
	input wire logic [5:0] code,
	// Millivolts out
	output logic [10:0] mv
);
	always_comb begin
		if (code <= `BVS_CODE_KNEE) begin
			mv = `BVS_MV_BASE + 11'(code) * `BVS_MV_STEP_LO;
		end else begin
			mv = `BVS_MV_KNEE + 11'(code - `BVS_CODE_KNEE) * `BVS_MV_STEP_HI;
		end
	end
endmodule : bvs_code_to_mv
`default_nettype wire

// *** verilog/bvs_defines.svh ***
// Purpose: Offsets, field positions, reset values and timing counts of the buck voltage register
// Assumes: 200 MHz clock
// Notes: Definitions only
`ifndef BVS_DEFINES_SVH
`define BVS_DEFINES_SVH
`define BVS_BUCK2_OFS 8'h17
`define BVS_BUCK1_OFS 8'h16
`define BVS_APPLY_OFS 8'h1A
`define BVS_BUCK2_RST 8'h99
`define BVS_BUCK1_RST 8'h80
`define BVS_PSKIP_BIT 7
`define BVS_RSVD_BIT 6
`define BVS_CODE_MSB 5
`define BVS_CODE_W 6
`define BVS_APPLY_BIT 0
`define BVS_APPLY_ALT_BIT 1
`define BVS_CLK_MHZ 200
`define BVS_BLANK_MS 5
`define BVS_BLANK_CYC (`BVS_BLANK_MS * 1000 * `BVS_CLK_MHZ)
`define BVS_CODE_KNEE 6'h32
`define BVS_MV_BASE 11'd850
`define BVS_MV_KNEE 11'd1350
`define BVS_MV_STEP_LO 11'd10
`define BVS_MV_STEP_HI 11'd25
`endif

// *** verilog/bvs_pkg.sv ***
// Purpose: Types of the buck voltage register block
// Assumes: Constants live in bvs_defines.svh
// Notes: None
package bvs_pkg;
	typedef enum logic [1:0] {BVS_IDLE, BVS_BLANK} bvs_blank_t;
	typedef logic [10:0] bvs_mv_t;
endpackage : bvs_pkg

// *** verilog/bvs_reg.sv ***
// Purpose: Voltage setting register of the second buck converter with apply and blanking
// Assumes: Register port from the management interface decoder, one write pulse per byte
// Notes: Blanking count is a parameter so simulation can shorten it
`timescale 1ns/100ps
`default_nettype none
`include "bvs_defines.svh"
// What this block does
// - Second buck register lives at 0x17, resets to 0x99 (code 19h, 1.100 V).
// - Writes to 0x17 take effect only while the password unlock is satisfied.
// - Any accepted write to 0x17 blanks over/under-voltage supervision for 5 ms.
// - New code reaches the converter only after apply or alternate apply at 0x1A.
// - Bit 7 set permits pulse-skip, clear forces PWM; resets set.
// - Code 0h is 0.850 V, 10 mV steps to 32h, then 25 mV steps.
// - First buck upper codes 24h to 3Fh use the same encoding.
// - Pulse-skip only entered at light load when permitted.
module bvs_reg
	import bvs_pkg::*;
#(
	parameter int unsigned BLANK_CYC = `BVS_BLANK_CYC
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// Password state from the protection logic
	input wire logic unlocked,
	// First buck code as stored elsewhere
	input wire logic [5:0] buck1_voltage_code,
	// Converter status pin, level, asynchronous
	input wire logic light_load,
	// Converter controls
	output logic [5:0] buck2_voltage_code,
	output logic [10:0] buck2_mv,
	output logic [10:0] buck1_mv,
	output logic pulse_skip_active,
	output logic supervisor_blank
);
	typedef struct packed {
		logic [5:0] code;
		logic pskip;
		logic [5:0] applied;
		bvs_blank_t blank;
		logic [31:0] cnt;
		logic [1:0] ll_sync;
		logic pskip_act;
		logic [7:0] rdata;
	} bvs_state_t;

	bvs_state_t s_r;
	bvs_state_t s_nxt;
	logic wr_hit;
	logic apply_hit;
	logic [7:0] reg_value;

	assign wr_hit = reg_wr && reg_addr == `BVS_BUCK2_OFS && unlocked;
	assign apply_hit = reg_wr && reg_addr == `BVS_APPLY_OFS
		&& (reg_wdata[`BVS_APPLY_BIT] || reg_wdata[`BVS_APPLY_ALT_BIT]);
	assign reg_value = {s_r.pskip, 1'b0, s_r.code};

	always_comb begin
		s_nxt = s_r;
		s_nxt.ll_sync = {s_r.ll_sync[0], light_load};
		if (wr_hit) begin
			s_nxt.code = reg_wdata[`BVS_CODE_MSB:0];
			s_nxt.pskip = reg_wdata[`BVS_PSKIP_BIT];
		end
		if (apply_hit) begin
			s_nxt.applied = s_r.code;
		end
		case (s_r.blank)
			BVS_IDLE: begin
				if (wr_hit) begin
					s_nxt.blank = BVS_BLANK;
					s_nxt.cnt = 32'(BLANK_CYC - 1);
				end
			end
			BVS_BLANK: begin
				if (wr_hit) begin
					s_nxt.cnt = 32'(BLANK_CYC - 1);
				end else if (s_r.cnt == 32'h0) begin
					s_nxt.blank = BVS_IDLE;
				end else begin
					s_nxt.cnt = s_r.cnt - 32'h1;
				end
			end
			default: begin
				s_nxt.blank = BVS_IDLE;
			end
		endcase
		s_nxt.pskip_act = s_r.pskip && s_r.ll_sync[1];
		s_nxt.rdata = (reg_addr == `BVS_BUCK2_OFS) ? reg_value : 8'h00;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r.code <= 6'(`BVS_BUCK2_RST & 8'h3F);
			s_r.pskip <= 1'b1;
			s_r.applied <= 6'(`BVS_BUCK2_RST & 8'h3F);
			s_r.blank <= BVS_IDLE;
			s_r.cnt <= 32'h0;
			s_r.ll_sync <= 2'h0;
			s_r.pskip_act <= 1'b0;
			s_r.rdata <= 8'h00;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign reg_rdata = s_r.rdata;
	assign buck2_voltage_code = s_r.applied;
	assign pulse_skip_active = s_r.pskip_act;
	assign supervisor_blank = (s_r.blank == BVS_BLANK);

	bvs_code_to_mv u_mv2 (
		.code(s_r.applied),
		.mv(buck2_mv)
	);

	bvs_code_to_mv u_mv1 (
		.code(buck1_voltage_code),
		.mv(buck1_mv)
	);
endmodule : bvs_reg
`default_nettype wire
